// File: design/lcd_col_port.v
// Host port, reset, strap and segment drive logic of an LCD column driver
`timescale 1ns/1ns
`default_nettype none
`include "lcd_port_defs.vh"

// Contract
// - Strap high: segment 1 shows column 0; strap low reverses mapping.
// - Frame high presets the 6-bit line counter from the start line.
// - Line latch rising edge latches row data; counter advances.
// - Host transfers and instructions execute on the two-phase clock; status and data reads load host_bus_out on the system clock.
// - Phase 1: data 1 V1, 0 V3; phase 0: data 1 V2, 0 V4.
// - RAM bit 1 gives light-on level, bit 0 light-off level.
// - Reset input low clears on/off register and start line to 0.
// - After reset, off state and line 0 hold until an instruction.
// - Eight-bit host bus, bit 7 most significant, bit 0 least.
// - Bus drives only during a selected read, otherwise released.
// - Without all three selects active, host inputs are ignored.
// - Reset input and strap act regardless of the selects.
// - Read/write and data/instruction choose input or output register.
// - Written display byte sits in input register, then moves to RAM.
// - Display write byte is captured at the strobe falling edge.
// - Decode 11 read data, 10 write data, 01 status, 00 instruction.
// - While busy writes are ignored, status and data reads still accepted; host waits for not busy.
module lcd_col_port (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Device pins: reset and strap
  input wire reset_n_in,
  input wire adc_strap,
  // Host port
  input wire sel_a_n,
  input wire sel_b_n,
  input wire sel_c,
  input wire data_instr,
  input wire read_write,
  input wire strobe,
  input wire [`BUS_W-1:0] host_bus_in,
  output reg [`BUS_W-1:0] host_bus_out,
  output wire host_bus_oe,
  // Companion row driver
  input wire ac_phase_in,
  input wire frame_sync_in,
  input wire line_latch_in,
  input wire phase_clk_a,
  input wire phase_clk_b,
  // Display RAM side
  input wire [`BUS_W-1:0] read_data_in,
  input wire [`SEG_COUNT-1:0] row_data_in,
  output reg [`LINE_W-1:0] line_addr_q,
  output reg ram_wr_q,
  output reg [`BUS_W-1:0] ram_wr_data_q,
  // Status and segment drive
  output reg display_on_q,
  output reg [`LINE_W-1:0] start_line_q,
  output reg busy_q,
  output wire [`LEVEL_W*`SEG_COUNT-1:0] segment_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire [`SYNC_W-1:0] pins_s;

  pin_sync #(.WIDTH(`SYNC_W)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({phase_clk_b, phase_clk_a, line_latch_in, frame_sync_in, ac_phase_in,
             read_write, data_instr, sel_c, sel_b_n, sel_a_n, strobe, adc_strap,
             reset_n_in, host_bus_in}),
    .pin_sync_out(pins_s)
  );

  wire [`BUS_W-1:0] bus_s = pins_s[7:0];
  wire reset_n_s = pins_s[8];
  wire adc_s = pins_s[9];
  wire strobe_s = pins_s[10];
  wire sel_a_n_s = pins_s[11];
  wire sel_b_n_s = pins_s[12];
  wire sel_c_s = pins_s[13];
  wire di_s = pins_s[14];
  wire rw_s = pins_s[15];
  wire ac_s = pins_s[16];
  wire frame_s = pins_s[17];
  wire latch_s = pins_s[18];
  wire phase_a_s = pins_s[19];

  // The second phase only qualifies the tick: work happens on a rise of phase A
  // while phase B is low, so overlapping phases never double-fire.
  wire phase_b_s = pins_s[20];

  // ---------------------------------------------------------------
  // Edge detection on synchronised levels
  // ---------------------------------------------------------------
  reg strobe_d_q;
  reg latch_d_q;
  reg phase_d_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_d_q <= 1'b0;
      latch_d_q <= 1'b0;
      phase_d_q <= 1'b0;
    end else begin
      strobe_d_q <= strobe_s;
      latch_d_q <= latch_s;
      phase_d_q <= phase_a_s;
    end
  end

  wire strobe_fall = strobe_d_q & ~strobe_s;
  wire latch_rise = latch_s & ~latch_d_q;
  wire phase_tick = phase_a_s & ~phase_d_q & ~phase_b_s;

  // ---------------------------------------------------------------
  // Host access decode
  // ---------------------------------------------------------------
  wire selected = ~sel_a_n_s & ~sel_b_n_s & sel_c_s;
  wire acc_wr_data = selected & di_s & ~rw_s;
  wire acc_wr_instr = selected & ~di_s & ~rw_s;
  wire acc_rd_status = selected & ~di_s & rw_s;
  wire acc_rd_data = selected & di_s & rw_s;

  assign host_bus_oe = selected & rw_s & strobe_s;

  // ---------------------------------------------------------------
  // Input register and instruction capture
  // ---------------------------------------------------------------
  reg [`BUS_W-1:0] in_reg_q;
  reg pend_data_q;
  reg pend_instr_q;

  wire accept_ok = reset_n_s & ~busy_q;
  wire take_data = strobe_fall & acc_wr_data & accept_ok;
  wire take_instr = strobe_fall & acc_wr_instr & accept_ok;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_reg_q <= `BYTE_ZERO;
      pend_data_q <= 1'b0;
      pend_instr_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (take_data || take_instr) begin
        in_reg_q <= bus_s;
        pend_data_q <= take_data;
        pend_instr_q <= take_instr;
        busy_q <= 1'b1;
      end else if (phase_tick) begin
        pend_data_q <= 1'b0;
        pend_instr_q <= 1'b0;
        busy_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Internal execution on the two-phase clock
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ram_wr_q <= 1'b0;
      ram_wr_data_q <= `BYTE_ZERO;
      display_on_q <= `DISPLAY_ON_RST;
      start_line_q <= `START_LINE_RST;
    end else begin
      ram_wr_q <= phase_tick & pend_data_q;
      if (phase_tick && pend_data_q) begin
        ram_wr_data_q <= in_reg_q;
      end
      if (!reset_n_s) begin
        display_on_q <= `DISPLAY_ON_RST;
        start_line_q <= `START_LINE_RST;
      end else if (phase_tick && pend_instr_q) begin
        if ((in_reg_q & `INSTR_ONOFF_MASK) == `INSTR_ONOFF_CODE) begin
          display_on_q <= in_reg_q[0];
        end else if ((in_reg_q & `INSTR_START_MASK) == `INSTR_START_CODE) begin
          start_line_q <= in_reg_q[`LINE_W-1:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data onto the host bus
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      host_bus_out <= `BYTE_ZERO;
    end else if (acc_rd_status) begin
      host_bus_out <= `BYTE_ZERO;
      host_bus_out[`STAT_BUSY_BIT] <= busy_q | ~reset_n_s;
      host_bus_out[`STAT_OFF_BIT] <= ~display_on_q;
      host_bus_out[`STAT_RESET_BIT] <= ~reset_n_s;
    end else if (acc_rd_data) begin
      host_bus_out <= read_data_in;
    end
  end

  // ---------------------------------------------------------------
  // Display line counter and data latch
  // ---------------------------------------------------------------
  reg [`SEG_COUNT-1:0] row_latch_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      line_addr_q <= `LINE_ZERO;
      row_latch_q <= `ROW_ZERO;
    end else begin
      if (frame_s) begin
        line_addr_q <= start_line_q;
      end else if (latch_rise) begin
        line_addr_q <= line_addr_q + `LINE_STEP;
      end
      if (latch_rise) begin
        row_latch_q <= display_on_q ? row_data_in : `ROW_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------
  // Segment drive level selection
  // ---------------------------------------------------------------
  genvar seg_i;
  generate
    for (seg_i = 0; seg_i < `SEG_COUNT; seg_i = seg_i + 1) begin : g_seg
      wire bit_v = adc_s ? row_latch_q[seg_i] : row_latch_q[`SEG_COUNT-1-seg_i];
      reg [`LEVEL_W-1:0] level_q;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          level_q <= `DRIVE_LEVEL_NONSEL_B;
        end else if (ac_s) begin
          level_q <= bit_v ? `DRIVE_LEVEL_SEL_A : `DRIVE_LEVEL_NONSEL_A;
        end else begin
          level_q <= bit_v ? `DRIVE_LEVEL_SEL_B : `DRIVE_LEVEL_NONSEL_B;
        end
      end
      assign segment_out[`LEVEL_W*seg_i +: `LEVEL_W] = level_q;
    end
  endgenerate

endmodule

`default_nettype wire

// File: design/lcd_port_defs.vh
// Constants for the column driver host port and segment drive logic
`ifndef LCD_PORT_DEFS_VH
`define LCD_PORT_DEFS_VH

// -----------------------------------------------------------------
// Widths
// -----------------------------------------------------------------
`define SEG_COUNT 64
`define LINE_W 6
`define BUS_W 8
`define SYNC_W 21

// -----------------------------------------------------------------
// Drive level codes on each segment output
// -----------------------------------------------------------------
`define LEVEL_W 2
`define DRIVE_LEVEL_SEL_A 2'h0
`define DRIVE_LEVEL_SEL_B 2'h1
`define DRIVE_LEVEL_NONSEL_A 2'h2
`define DRIVE_LEVEL_NONSEL_B 2'h3

// -----------------------------------------------------------------
// Instruction codes (written with data_instr low)
// -----------------------------------------------------------------
`define INSTR_ONOFF_MASK 8'hFE
`define INSTR_ONOFF_CODE 8'h3E
`define INSTR_START_MASK 8'hC0
`define INSTR_START_CODE 8'hC0

// -----------------------------------------------------------------
// Status byte bit positions
// -----------------------------------------------------------------
`define STAT_BUSY_BIT 7
`define STAT_OFF_BIT 5
`define STAT_RESET_BIT 4

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define START_LINE_RST 6'h00
`define DISPLAY_ON_RST 1'b0
`define LINE_ZERO 6'h00
`define LINE_STEP 6'h01
`define BYTE_ZERO 8'h00
`define ROW_ZERO 64'h0000000000000000

`endif

// File: design/pin_sync.v
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pins and synchronised copies
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_sync_out
);

  reg [WIDTH-1:0] meta_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b0}};
      pin_sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q <= pin_in;
      pin_sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: sim/phase_clock_model.sv
// Two-phase clock of the companion driver
`timescale 1ns/1ns
`default_nettype none
module phase_clock_model (
  // Phase outputs
  output logic phase_clk_a,
  output logic phase_clk_b
);
  // Non-overlapping phases, unrelated to the system clock
  initial begin
    {phase_clk_a, phase_clk_b} = 2'h0;
    forever begin
      #23 phase_clk_a = 1'b1;
      #31 phase_clk_a = 1'b0;
      #23 phase_clk_b = 1'b1;
      #31 phase_clk_b = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: sim/lcd_col_port_assertions.sv
// Assertions on the column driver host and display ports
`timescale 1ns/1ns
`default_nettype none
module lcd_col_port_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n_in,
  // Host pins
  input wire logic sel_a_n,
  input wire logic sel_b_n,
  input wire logic sel_c,
  input wire logic read_write,
  input wire logic strobe,
  // Companion driver pins
  input wire logic frame_sync_in,
  input wire logic line_latch_in,
  // Design outputs
  input wire logic host_bus_oe,
  input wire logic ram_wr_q,
  input wire logic busy_q,
  input wire logic display_on_q,
  input wire logic [5:0] line_addr_q,
  input wire logic [5:0] start_line_q
);
  wire sel_ok = !sel_a_n && !sel_b_n && sel_c;
  wire rd_sel = sel_ok && read_write && strobe;
  reg [5:0] base_q;
  // ----
  // Counter value at each latch rise
  // ----
  always @(posedge clk or posedge rst)
    if (rst) base_q <= 6'h00;
    else if ($rose(line_latch_in)) base_q <= line_addr_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  oe_gate_a: assert property (host_bus_oe |-> $past(rd_sel, 2))
    else $error("bus driven outside a read");
  wr_pulse_a: assert property (ram_wr_q |=> !ram_wr_q)
    else $error("long RAM write");
  wr_busy_a: assert property (ram_wr_q |-> $past(busy_q) && !busy_q)
    else $error("RAM write off tick");
  busy_end_a: assert property ($rose(busy_q) |-> ##[1:20] !busy_q)
    else $error("busy stuck");
  busy_sel_a: assert property ($rose(busy_q) |-> $past(sel_ok, 3))
    else $error("busy unselected");
  rst_pin_a: assert property (!$past(reset_n_in, 4) && !$past(reset_n_in, 3)
    |-> !display_on_q && start_line_q == 6'h00) else $error("reset pin ignored");
  preset_a: assert property ($past(frame_sync_in, 5) && $past(frame_sync_in, 4)
    && $past(frame_sync_in, 3) |-> line_addr_q == start_line_q) else $error("no preset");
  step_a: assert property ($rose(line_latch_in) && !frame_sync_in
    |-> ##[2:4] line_addr_q == base_q + 6'h01) else $error("no line step");
endmodule
bind lcd_col_port lcd_col_port_checker chk (.clk(clk), .rst(rst),
  .reset_n_in(reset_n_in), .sel_a_n(sel_a_n), .sel_b_n(sel_b_n), .sel_c(sel_c),
  .read_write(read_write), .strobe(strobe), .frame_sync_in(frame_sync_in),
  .line_latch_in(line_latch_in), .host_bus_oe(host_bus_oe), .ram_wr_q(ram_wr_q),
  .busy_q(busy_q), .display_on_q(display_on_q), .line_addr_q(line_addr_q),
  .start_line_q(start_line_q));
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the column driver port
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, rst, reset_n_in, adc_strap, sel_a_n, sel_b_n, sel_c, data_instr;
  logic read_write, strobe, ac_phase_in, frame_sync_in, line_latch_in, phase_clk_a;
  logic phase_clk_b, host_bus_oe, ram_wr_q, display_on_q, busy_q;
  logic [7:0] mpu_bus, host_bus_out, read_data_in, ram_wr_data_q, b;
  logic [63:0] row_data_in;
  logic [5:0] line_addr_q, start_line_q;
  logic [127:0] segment_out;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int check_count = 0;
  wire [7:0] host_bus_in = host_bus_oe ? host_bus_out : mpu_bus;
  lcd_col_port dut (
    .clk(clk), .rst(rst), .reset_n_in(reset_n_in), .adc_strap(adc_strap),
    .sel_a_n(sel_a_n), .sel_b_n(sel_b_n), .sel_c(sel_c), .data_instr(data_instr),
    .read_write(read_write), .strobe(strobe), .host_bus_in(host_bus_in),
    .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe), .ac_phase_in(ac_phase_in),
    .frame_sync_in(frame_sync_in), .line_latch_in(line_latch_in),
    .phase_clk_a(phase_clk_a), .phase_clk_b(phase_clk_b), .read_data_in(read_data_in),
    .row_data_in(row_data_in), .line_addr_q(line_addr_q), .ram_wr_q(ram_wr_q),
    .ram_wr_data_q(ram_wr_data_q), .display_on_q(display_on_q),
    .start_line_q(start_line_q), .busy_q(busy_q), .segment_out(segment_out)
  );
  phase_clock_model partner (
    .phase_clk_a(phase_clk_a),
    .phase_clk_b(phase_clk_b)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
    check_count++;
    if (e !== g) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // Host access with strobe pulse, then wait for not busy
  task automatic acc(logic [2:0] s, logic di, logic rw, logic [7:0] d, logic [7:0] e);
    {sel_a_n, sel_b_n, sel_c, data_instr, read_write, mpu_bus} = {s, di, rw, d};
    cyc(3);
    strobe = 1'b1;
    cyc(4);
    if (rw) chk("oe", 1, host_bus_oe);
    if (rw) chk("read", e, host_bus_out);
    strobe = 1'b0;
    cyc(5);
    {sel_a_n, sel_b_n, sel_c} = 3'b110;
    for (int i = 0; i < 40 && busy_q !== 1'b0; i++) cyc(1);
  endtask
  task automatic latch;
    line_latch_in = 1'b1;
    cyc(5);
    line_latch_in = 1'b0;
    cyc(6);
  endtask
  function automatic logic [127:0] seg_exp(logic [63:0] r, logic s, logic a);
    logic d;
    for (int i = 0; i < 64; i++) begin
      d = s ? r[i] : r[63-i];
      seg_exp[2*i +: 2] = a ? (d ? 2'h0 : 2'h2) : (d ? 2'h1 : 2'h3);
    end
  endfunction
  // Each RAM write pulse takes the oldest expected byte
  always @(negedge clk) if (ram_wr_q === 1'b1) begin
    if (exp_q.size() == 0) chk("wr_extra", 0, 1);
    else chk("wr_data", exp_q.pop_front(), ram_wr_data_q);
  end
  initial begin
    {rst, reset_n_in, adc_strap, strobe, data_instr, read_write} = 6'b101000;
    {sel_a_n, sel_b_n, sel_c, ac_phase_in, frame_sync_in, line_latch_in} = 6'b110000;
    {mpu_bus, read_data_in, row_data_in} = '0;
    void'($urandom(70443));
    cyc(2);
    rst = 1'b0;
    cyc(4);
    chk("on", 0, display_on_q);
    chk("start", 0, start_line_q);
    acc(3'b001, 0, 1, 0, 8'hB0);
    acc(3'b001, 1, 0, 8'h5A, 0);
    reset_n_in = 1'b1;
    cyc(20);
    chk("on", 0, display_on_q);
    chk("start", 0, start_line_q);
    acc(3'b001, 0, 0, 8'h3F, 0);
    acc(3'b001, 0, 0, 8'hC5, 0);
    chk("on", 1, display_on_q);
    chk("start", 6'h05, start_line_q);
    for (int i = 0; i < 8; i++) begin
      if (i != 1) acc(i[2:0], 0, 0, 8'h3E, 0);
      if (i != 1) acc(i[2:0], 1, 0, 8'hA5, 0);
    end
    chk("on", 1, display_on_q);
    repeat (6) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      acc(3'b001, 1, 0, b, 0);
    end
    acc(3'b001, 0, 1, 0, 8'h00);
    read_data_in = 8'($urandom);
    acc(3'b001, 1, 1, 0, read_data_in);
    chk("oe", 0, host_bus_oe);
    row_data_in = {$urandom, $urandom};
    for (int m = 0; m < 2; m++) begin
      ac_phase_in = ~m[0];
      latch();
      chk("seg", seg_exp(row_data_in, adc_strap, ac_phase_in), segment_out);
    end
    frame_sync_in = 1'b1;
    cyc(6);
    chk("line", 6'h05, line_addr_q);
    frame_sync_in = 1'b0;
    cyc(3);
    latch();
    chk("line", 6'h06, line_addr_q);
    reset_n_in = 1'b0;
    cyc(6);
    chk("on", 0, display_on_q);
    chk("start", 0, start_line_q);
    latch();
    chk("seg", seg_exp(64'h0, adc_strap, ac_phase_in), segment_out);
    // Strap only moves while the block is held in reset
    rst = 1'b1;
    adc_strap = 1'b0;
    reset_n_in = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(4);
    chk("on", 0, display_on_q);
    chk("start", 0, start_line_q);
    acc(3'b001, 0, 0, 8'h3F, 0);
    for (int m = 0; m < 2; m++) begin
      ac_phase_in = m[0];
      latch();
      chk("seg", seg_exp(row_data_in, adc_strap, ac_phase_in), segment_out);
    end
    chk("left", 0, exp_q.size());
    print_verdict();
  end
endmodule
`default_nettype wire
